// [src/pefr_event_flags.sv]
`default_nettype none
// What this block does
// R1: bit 11 is a read/write enable for the partner acknowledge event, reset zero.
// R2: bit 10 is a read/write enable for the link down event, reset zero.
// R3: bit 9 is a read/write enable for the remote fault event, reset zero.
// R4: bit 8 is a read/write enable for the link up event, reset zero.
// R5: bit 7 is a read-only sticky flag set by a jabber condition, reset zero.
// R6: bit 6 is a read-only sticky flag set by a receive error, reset zero.
// R7: bit 5 is a read-only sticky flag set by a received page, reset zero.
// R8: bit 4 is a read-only sticky flag set by a parallel detect fault, reset zero.
// R9: bit 3 is a read-only sticky flag set by partner acknowledge, reset zero.
// R10: bit 2 is a read-only sticky flag set when the link goes down, reset zero.
// R11: bit 1 is a read-only sticky flag set by a remote fault, reset zero.
// R12: bit 0 is a read-only sticky flag set when the link comes up, reset zero.
// R13: bits 15 to 12 enable jabber, receive error, page and parallel fault, reset zero.
// R14: bit 12 lets the parallel detect fault event raise the interrupt.
// R15: a register read clears each flag unless its event recurs in that cycle.
// R16: the interrupt output irq_n_o is low while any flag is set together with its enable.
module pefr_event_flags #(
	parameter int NUM_EVT = pefr_pkg::EVT_COUNT
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	input wire logic [NUM_EVT-1:0] evt_async_i,
	output logic irq_n_o
);
	logic [NUM_EVT-1:0] enable_r;
	logic [NUM_EVT-1:0] flag_r;
	logic [15:0] rdata_r;
	logic [NUM_EVT-1:0] evt_pulse;

	pefr_event_sync #(.WIDTH(NUM_EVT)) u_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.evt_async_i(evt_async_i),
		.evt_pulse_o(evt_pulse)
	);

	wire hit_w = (reg_addr_i == pefr_pkg::EVT_REG_ADDR);
	wire rd_hit_w = hit_w & reg_rd_i;
	wire wr_hit_w = hit_w & reg_wr_i;
	// R1 R2 R3 R4 R13 only the upper byte is writable
	wire [NUM_EVT-1:0] enable_nxt = wr_hit_w ?
		reg_wdata_i[pefr_pkg::ENABLE_LSB +: NUM_EVT] : enable_r;
	// R5 R6 R7 R8 R9 R10 R11 R12 R15 set wins over read clear
	wire [NUM_EVT-1:0] flag_nxt = evt_pulse | (rd_hit_w ? '0 : flag_r);
	wire [15:0] rdata_nxt = hit_w ? {enable_r, flag_r} : 16'h0000;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			enable_r <= pefr_pkg::ENABLE_RESET;
			flag_r <= pefr_pkg::FLAG_RESET;
			rdata_r <= 16'h0000;
		end else begin
			enable_r <= enable_nxt;
			flag_r <= flag_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata_o = rdata_r;
	assign irq_n_o = ~|(flag_r & enable_r); // R14 R16

	flag_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R15
		rd_hit_w && !evt_pulse[0] |=> !flag_r[0])
		else $error("flag not cleared by read");
	flag_sticky_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R12
		flag_r[0] && !rd_hit_w |=> flag_r[0])
		else $error("flag lost without read");
	flag_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R9
		evt_pulse[3] |=> flag_r[3])
		else $error("event not latched");
	jabber_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R5
		evt_pulse[7] |=> flag_r[7])
		else $error("jabber not latched");
	enable_wr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R1
		wr_hit_w |=> enable_r[3] == $past(reg_wdata_i[11]))
		else $error("enable not written");
	enable_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R13
		!wr_hit_w |=> $stable(enable_r))
		else $error("enable changed without write");
	irq_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R14
		flag_r[4] && enable_r[4] |-> !irq_n_o)
		else $error("interrupt not raised");
	irq_idle_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R16
		(flag_r & enable_r) == '0 |-> irq_n_o)
		else $error("spurious interrupt");
	read_data_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R2
		rd_hit_w |=> reg_rdata_o[10] == $past(enable_r[2]))
		else $error("read data wrong");

	up_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R12
		evt_pulse[0] |=> flag_r[0])
		else $error("link up event not latched");

	rfault_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R11
		evt_pulse[1] |=> flag_r[1])
		else $error("remote fault event not latched");

	down_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R10
		evt_pulse[2] |=> flag_r[2])
		else $error("link down event not latched");

	pdf_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R8
		evt_pulse[4] |=> flag_r[4])
		else $error("parallel fault event not latched");

	page_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R7
		evt_pulse[5] |=> flag_r[5])
		else $error("page event not latched");

	rxerr_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R6
		evt_pulse[6] |=> flag_r[6])
		else $error("receive error event not latched");

	rfault_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R15
		rd_hit_w && !evt_pulse[1] |=> !flag_r[1])
		else $error("remote fault flag not cleared by read");

	down_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R15
		rd_hit_w && !evt_pulse[2] |=> !flag_r[2])
		else $error("link down flag not cleared by read");

	ack_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R15
		rd_hit_w && !evt_pulse[3] |=> !flag_r[3])
		else $error("partner ack flag not cleared by read");

	pdf_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R15
		rd_hit_w && !evt_pulse[4] |=> !flag_r[4])
		else $error("parallel fault flag not cleared by read");

	page_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R15
		rd_hit_w && !evt_pulse[5] |=> !flag_r[5])
		else $error("page flag not cleared by read");

	rxerr_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R15
		rd_hit_w && !evt_pulse[6] |=> !flag_r[6])
		else $error("receive error flag not cleared by read");

	jabber_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R15
		rd_hit_w && !evt_pulse[7] |=> !flag_r[7])
		else $error("jabber flag not cleared by read");

	up_enable_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R4
		wr_hit_w |=> enable_r[0] == $past(reg_wdata_i[8]))
		else $error("link up enable not written");

	rfault_enable_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R3
		wr_hit_w |=> enable_r[1] == $past(reg_wdata_i[9]))
		else $error("remote fault enable not written");

	down_enable_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R2
		wr_hit_w |=> enable_r[2] == $past(reg_wdata_i[10]))
		else $error("link down enable not written");

	pdf_enable_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R14
		wr_hit_w |=> enable_r[4] == $past(reg_wdata_i[12]))
		else $error("parallel fault enable not written");

	page_enable_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R13
		wr_hit_w |=> enable_r[5] == $past(reg_wdata_i[13]))
		else $error("page enable not written");

	rxerr_enable_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R13
		wr_hit_w |=> enable_r[6] == $past(reg_wdata_i[14]))
		else $error("receive error enable not written");

	jabber_enable_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R13
		wr_hit_w |=> enable_r[7] == $past(reg_wdata_i[15]))
		else $error("jabber enable not written");

	up_irq_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R4
		evt_pulse[0] && enable_r[0] && !wr_hit_w |=> !irq_n_o)
		else $error("link up interrupt not raised");

	rfault_irq_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R3
		evt_pulse[1] && enable_r[1] && !wr_hit_w |=> !irq_n_o)
		else $error("remote fault interrupt not raised");

	down_irq_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R2
		evt_pulse[2] && enable_r[2] && !wr_hit_w |=> !irq_n_o)
		else $error("link down interrupt not raised");

	ack_irq_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R1
		evt_pulse[3] && enable_r[3] && !wr_hit_w |=> !irq_n_o)
		else $error("partner ack interrupt not raised");

	pdf_irq_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R14
		evt_pulse[4] && enable_r[4] && !wr_hit_w |=> !irq_n_o)
		else $error("parallel fault interrupt not raised");

	page_irq_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R13
		evt_pulse[5] && enable_r[5] && !wr_hit_w |=> !irq_n_o)
		else $error("page interrupt not raised");

	rxerr_irq_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R13
		evt_pulse[6] && enable_r[6] && !wr_hit_w |=> !irq_n_o)
		else $error("receive error interrupt not raised");

	jabber_irq_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R13
		evt_pulse[7] && enable_r[7] && !wr_hit_w |=> !irq_n_o)
		else $error("jabber interrupt not raised");

	flag_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R15
		rd_hit_w |=> reg_rdata_o[7:0] == $past(flag_r))
		else $error("read did not return the flags before clearing");

	enable_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R13
		hit_w |=> reg_rdata_o[15:8] == $past(enable_r))
		else $error("read did not return the enables");

	unmapped_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R13
		!hit_w |=> reg_rdata_o == 16'h0000)
		else $error("other address returned data");

	flag_keep_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R15
		!rd_hit_w |=> ($past(flag_r) & ~flag_r) == '0)
		else $error("flag cleared without a read");

	reset_state_a: assert property (@(posedge core_clk_i) // R5 R13
		!rst_n_i |=> flag_r == '0 && enable_r == '0 && reg_rdata_o == 16'h0000 && irq_n_o)
		else $error("state not cleared by reset");
endmodule // pefr_event_flags
`default_nettype wire

// [src/pefr_pkg.sv]
`default_nettype none
package pefr_pkg;
	localparam logic [4:0] EVT_REG_ADDR = 5'h1b;
	localparam int EVT_COUNT = 8;
	localparam int FLAG_LSB = 0;
	localparam int ENABLE_LSB = 8;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	// event bit positions within the flag byte
	localparam int EV_LINK_UP = 0;
	localparam int EV_REMOTE_FAULT = 1;
	localparam int EV_LINK_DOWN = 2;
	localparam int EV_PARTNER_ACK = 3;
	localparam int EV_PAR_DET_FAULT = 4;
	localparam int EV_PAGE_RX = 5;
	localparam int EV_RX_ERROR = 6;
	localparam int EV_JABBER = 7;
	localparam int SYNC_STAGES = 3;
endpackage
`default_nettype wire

// [src/pefr_event_sync.sv]
`default_nettype none
// three-stage synchroniser with rising-edge pulse per event line
module pefr_event_sync #(
	parameter int WIDTH = 8
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] evt_async_i,
	output logic [WIDTH-1:0] evt_pulse_o
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync2_r;
	logic [WIDTH-1:0] sync3_r;
	logic [WIDTH-1:0] level_r;
	wire [WIDTH-1:0] agree_w = ~(sync2_r ^ sync3_r);
	wire [WIDTH-1:0] level_nxt = (agree_w & sync3_r) | (~agree_w & level_r);
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			meta_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
			level_r <= '0;
		end else begin
			meta_r <= evt_async_i;
			sync2_r <= meta_r;
			sync3_r <= sync2_r;
			level_r <= level_nxt;
		end
	end
	assign evt_pulse_o = level_nxt & ~level_r;
endmodule // pefr_event_sync
`default_nettype wire

// [dv/pefr_mgmt_model.sv]
`default_nettype none
// management controller side: one strobed access per call
module pefr_mgmt_model (
	input wire logic core_clk_i,
	input wire logic [15:0] reg_rdata_i,
	output logic [4:0] reg_addr_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [15:0] reg_wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{reg_addr_o, reg_wr_o, reg_rd_o, reg_wdata_o} = '0;
	end
	task acc(input logic [4:0] a, input logic w, input logic [15:0] d, output logic [15:0] q);
		@(negedge core_clk_i);
		{reg_addr_o, reg_wr_o, reg_rd_o, reg_wdata_o} = {a, w, !w, d};
		@(negedge core_clk_i);
		q = reg_rdata_i;
		// released data shows the inverse, not the last value
		{reg_addr_o, reg_wr_o, reg_rd_o, reg_wdata_o} = {5'h00, 2'b00, ~d};
	endtask
endmodule // pefr_mgmt_model
`default_nettype wire

// [dv/phy_event_flag_register_tb.sv]
`default_nettype none
module phy_event_flag_register_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [4:0] ra = pefr_pkg::EVT_REG_ADDR;
	logic core_clk_i = 0;
	logic rst_n_i = 0;
	logic [7:0] evt = '0;
	logic [4:0] a;
	logic w, r, irq_n;
	logic [15:0] wd, rd, q;
	int fail_count = 0;
	int n_checks = 0;
	always #5 core_clk_i = ~core_clk_i;
	pefr_mgmt_model pefr_mgmt_model_i (.core_clk_i(core_clk_i), .reg_rdata_i(rd),
		.reg_addr_o(a), .reg_wr_o(w), .reg_rd_o(r), .reg_wdata_o(wd));
	pefr_event_flags pefr_event_flags_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.reg_addr_i(a), .reg_wr_i(w), .reg_rd_i(r), .reg_wdata_i(wd), .reg_rdata_o(rd),
		.evt_async_i(evt), .irq_n_o(irq_n));
	task chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#20000;
		fail_count++;
		conclude();
	end
	initial begin
		repeat (3) @(negedge core_clk_i);
		rst_n_i = 1;
		pefr_mgmt_model_i.acc(ra, 0, 16'h0000, q);
		chk(q, 16'h0000);
		pefr_mgmt_model_i.acc(ra, 1, 16'hffff, q);
		pefr_mgmt_model_i.acc(ra, 0, 16'h0000, q);
		chk(q, 16'hff00);
		$display("test reset and write done");
		for (int i = 0; i < 8; i++) begin
			evt[i] = 1;
			repeat (6) @(negedge core_clk_i);
			chk({15'h0, irq_n}, 16'h0000);
			pefr_mgmt_model_i.acc(ra, 0, 16'h0000, q);
			chk(q, 16'hff00 | (16'h0001 << i));
			evt[i] = 0;
			pefr_mgmt_model_i.acc(ra, 0, 16'h0000, q);
			chk(q, 16'hff00);
			chk({15'h0, irq_n}, 16'h0001);
		end
		$display("test event flags done");
		pefr_mgmt_model_i.acc(ra, 1, 16'h00ff, q);
		evt[4] = 1;
		repeat (6) @(negedge core_clk_i);
		chk({15'h0, irq_n}, 16'h0001);
		pefr_mgmt_model_i.acc(ra, 0, 16'h0000, q);
		chk(q, 16'h0010);
		pefr_mgmt_model_i.acc(5'h1a, 1, 16'h0f00, q);
		pefr_mgmt_model_i.acc(5'h1a, 0, 16'h0000, q);
		chk(q, 16'h0000);
		pefr_mgmt_model_i.acc(ra, 0, 16'h0000, q);
		chk(q, 16'h0000);
		$display("test mask and unmapped done");
		pefr_mgmt_model_i.acc(ra, 1, 16'h0100, q);
		evt[1] = 1;
		repeat (6) @(negedge core_clk_i);
		chk({15'h0, irq_n}, 16'h0001);
		evt[0] = 1;
		repeat (6) @(negedge core_clk_i);
		chk({15'h0, irq_n}, 16'h0000);
		pefr_mgmt_model_i.acc(5'h1a, 0, 16'h0000, q);
		chk(q, 16'h0000);
		pefr_mgmt_model_i.acc(ra, 0, 16'h0000, q);
		chk(q, 16'h0103);
		chk({15'h0, irq_n}, 16'h0001);
		$display("test single enable done");
		conclude();
	end
endmodule // phy_event_flag_register_tb
`default_nettype wire
